// ### core/tmr8_pkg.sv
/*
 * Package for the 8-bit single-compare timer: field layouts, mode and
 * clock-select encodings, extreme values, reset values and carrier structs.
 * Assumes a single 50 MHz clock domain with synchronous active-low reset.
 */
package tmr8_pkg;

   // *********************************************************************
   // Extreme and reset values of the count and compare
   // *********************************************************************
   localparam logic [7:0] count_bottom = 8'h00;
   localparam logic [7:0] count_max    = 8'hff;
   localparam logic [7:0] count_reset  = 8'h00;
   localparam logic [7:0] compare_reset = 8'h00;

   // *********************************************************************
   // Prescaler taps (log2 of the system clock division ratios)
   // *********************************************************************
   localparam int unsigned presc_width = 10;
   localparam int unsigned tap_div8    = 3;
   localparam int unsigned tap_div64   = 6;
   localparam int unsigned tap_div256  = 8;
   localparam int unsigned tap_div1024 = 10;

   // *********************************************************************
   // Encodings
   // *********************************************************************
   typedef enum logic [1:0] {
      wave_normal = 2'h0,
      wave_phase  = 2'h1,
      wave_ctc    = 2'h2,
      wave_fast   = 2'h3
   } wave_mode_type;

   typedef enum logic [2:0] {
      clk_stopped  = 3'h0,
      clk_div1     = 3'h1,
      clk_div8     = 3'h2,
      clk_div64    = 3'h3,
      clk_div256   = 3'h4,
      clk_div1024  = 3'h5,
      clk_ext_fall = 3'h6,
      clk_ext_rise = 3'h7
   } clock_select_type;

   localparam logic [1:0] com_none   = 2'h0;
   localparam logic [1:0] com_toggle = 2'h1;
   localparam logic [1:0] com_clear  = 2'h2;
   localparam logic [1:0] com_set    = 2'h3;

   // *********************************************************************
   // Carriers
   // *********************************************************************
   typedef struct packed {
      clock_select_type clock_select_field;
      wave_mode_type    wave_mode_field;
      logic [1:0]       compare_output_mode_field;
   } timer_control_type;

   typedef struct packed {
      logic       count_write;
      logic [7:0] count_wdata;
      logic       compare_write;
      logic [7:0] compare_wdata;
      logic       force_compare_strobe;
   } cpu_write_type;

   typedef struct packed {
      logic overflow_flag;
      logic compare_flag;
   } timer_flag_type;

   typedef struct packed {
      logic overflow_clear;
      logic compare_clear;
   } flag_clear_type;

endpackage : tmr8_pkg

// ### core/tmr8_tick_gen.sv
/*
 * Timer tick generator: prescaler and clock select, one-cycle enable out.
 * Assumes the external count pin is already synchronous to clock.
 */
`timescale 1ns/10ps
module tmr8_tick_gen (
   input  wire logic                          clock,
   input  wire logic                          rst_n,
   input  wire tmr8_pkg::clock_select_type    clock_select_field,
   input  wire logic                          external_count_pin,
   output logic                               timer_tick
);

   logic [tmr8_pkg::presc_width-1:0] presc_q;
   logic [tmr8_pkg::presc_width-1:0] presc_d;
   logic                             pin_q;
   logic                             pin_d;

   always_comb begin
      presc_d = presc_q + 1'b1;
      pin_d   = external_count_pin;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         presc_q <= '0;
         pin_q   <= 1'b0;
      end else begin
         presc_q <= presc_d;
         pin_q   <= pin_d;
      end
   end

   // Taps fire when all lower prescaler bits are ones
   function automatic logic tap(input logic [tmr8_pkg::presc_width-1:0] p,
                                input int unsigned n);
      logic [tmr8_pkg::presc_width-1:0] m;
      m = ~({tmr8_pkg::presc_width{1'b1}} << n);
      return (p & m) == m;
   endfunction : tap

   always_comb begin
      case (clock_select_field)
         tmr8_pkg::clk_stopped:  timer_tick = 1'b0;
         tmr8_pkg::clk_div1:     timer_tick = 1'b1;
         tmr8_pkg::clk_div8:     timer_tick = tap(presc_q, tmr8_pkg::tap_div8);
         tmr8_pkg::clk_div64:    timer_tick = tap(presc_q, tmr8_pkg::tap_div64);
         tmr8_pkg::clk_div256:   timer_tick = tap(presc_q, tmr8_pkg::tap_div256);
         tmr8_pkg::clk_div1024:  timer_tick = tap(presc_q, tmr8_pkg::tap_div1024);
         tmr8_pkg::clk_ext_fall: timer_tick = pin_q & ~external_count_pin;
         tmr8_pkg::clk_ext_rise: timer_tick = ~pin_q & external_count_pin;
         default:                timer_tick = 1'b0;
      endcase
   end

endmodule : tmr8_tick_gen

// ### core/tmr8_timer.sv
/*
 * 8-bit timer/counter with one compare channel, waveform output and flags.
 * Assumes all inputs synchronous to clock; CPU writes are one-cycle strobes.
 */
`timescale 1ns/10ps
// Functional notes
// - Count zero raises bottom indication
// - Count all ones raises max indication
// - Top is max or compare, per mode
// - Tick from prescaler or pin, selected
// - Select zero stops the counter
// - Each tick clears, increments or decrements
// - CPU reads and writes count anytime
// - CPU count write beats counter update
// - Two mode bits set count sequence
// - Overflow flag set per mode
// - Eight-bit comparator signals equality continuously
// - Compare flag set on next tick
// - Compare irq: flag, enable, global enable
// - Flag cleared on ack or write-one
// - Compare double-buffered only in PWM modes
// - Buffer copies at max only
// - CPU compare access hits buffer or active
// - Force strobe acts like match, non-PWM
// - Count write blocks match next tick
// - Waveform from match, modes, max, bottom
// - Wave output kept across mode change
// - Output mode bits take effect immediately
// - Mode zero counts up, wraps, overflows
// - Mode two clears on compare match
// - Mode three single-slope fast PWM
// - Output mode zero: no output action
module tmr8_timer (
   input  wire logic                          clock,
   input  wire logic                          rst_n,
   input  wire tmr8_pkg::timer_control_type   timer_control_reg,
   input  wire tmr8_pkg::cpu_write_type       cpu_write,
   input  wire tmr8_pkg::flag_clear_type      flag_clear,
   input  wire logic                          overflow_irq_ack,
   input  wire logic                          compare_irq_ack,
   input  wire logic                          overflow_irq_enable,
   input  wire logic                          compare_irq_enable,
   input  wire logic                          global_irq_enable,
   input  wire logic                          external_count_pin,
   output logic [7:0]                         count_value,
   output logic [7:0]                         compare_value,
   output tmr8_pkg::timer_flag_type           timer_flag_reg,
   output logic                               overflow_irq,
   output logic                               compare_irq,
   output logic                               wave_output
);

   // *********************************************************************
   // State
   // *********************************************************************
   logic [7:0] count_q, count_d;
   logic [7:0] active_q, active_d;
   logic [7:0] buffer_q, buffer_d;
   logic       down_q, down_d;
   logic       block_q, block_d;
   logic       wave_q, wave_d;
   logic       ovf_q, ovf_d;
   logic       cmpf_q, cmpf_d;
   logic       timer_tick;

   tmr8_pkg::wave_mode_type mode;
   logic [1:0]              com;
   logic                    pwm_mode;
   logic                    at_bottom;
   logic                    at_max;
   logic                    at_top;
   logic [7:0]              top_value;
   logic                    match_raw;
   logic                    match;

   assign mode = timer_control_reg.wave_mode_field;
   assign com  = timer_control_reg.compare_output_mode_field;

   tmr8_tick_gen u_tick (
      .clock              (clock),
      .rst_n              (rst_n),
      .clock_select_field (timer_control_reg.clock_select_field),
      .external_count_pin (external_count_pin),
      .timer_tick         (timer_tick)
   );

   // *********************************************************************
   // Indications and comparator
   // *********************************************************************
   always_comb begin
      pwm_mode  = (mode == tmr8_pkg::wave_phase) || (mode == tmr8_pkg::wave_fast);
      at_bottom = (count_q == tmr8_pkg::count_bottom);
      at_max    = (count_q == tmr8_pkg::count_max);
      top_value = (mode == tmr8_pkg::wave_ctc) ? active_q : tmr8_pkg::count_max;
      at_top    = (count_q == top_value);
      match_raw = (count_q == active_q);
      match     = match_raw && !block_q;
   end

   // *********************************************************************
   // Counter and compare registers
   // *********************************************************************
   always_comb begin
      count_d  = count_q;
      down_d   = down_q;
      active_d = active_q;
      buffer_d = buffer_q;
      block_d  = block_q;
      if (timer_tick) begin
         block_d = 1'b0;
         case (mode)
            tmr8_pkg::wave_normal: count_d = count_q + 8'h01;
            tmr8_pkg::wave_ctc:
               count_d = at_top ? tmr8_pkg::count_bottom : count_q + 8'h01;
            tmr8_pkg::wave_fast: count_d = count_q + 8'h01;
            tmr8_pkg::wave_phase: begin
               if (!down_q && at_max) begin
                  down_d  = 1'b1;
                  count_d = count_q - 8'h01;
               end else if (down_q && at_bottom) begin
                  down_d  = 1'b0;
                  count_d = count_q + 8'h01;
               end else begin
                  count_d = down_q ? count_q - 8'h01 : count_q + 8'h01;
               end
            end
            default: count_d = count_q;
         endcase
         // Glitch-free update at top (fast) or top of dual slope
         if (pwm_mode && at_max) begin
            active_d = buffer_q;
         end
      end
      if (!pwm_mode) begin
         down_d = 1'b0;
      end
      if (cpu_write.count_write) begin
         count_d = cpu_write.count_wdata;
         block_d = 1'b1;
      end
      if (cpu_write.compare_write) begin
         if (pwm_mode) begin
            buffer_d = cpu_write.compare_wdata;
         end else begin
            active_d = cpu_write.compare_wdata;
            buffer_d = cpu_write.compare_wdata;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count_q  <= tmr8_pkg::count_reset;
         active_q <= tmr8_pkg::compare_reset;
         buffer_q <= tmr8_pkg::compare_reset;
         down_q   <= 1'b0;
         block_q  <= 1'b0;
      end else begin
         count_q  <= count_d;
         active_q <= active_d;
         buffer_q <= buffer_d;
         down_q   <= down_d;
         block_q  <= block_d;
      end
   end

   // *********************************************************************
   // Flags and waveform
   // *********************************************************************
   always_comb begin
      ovf_d   = ovf_q;
      cmpf_d  = cmpf_q;
      wave_d  = wave_q;
      if (overflow_irq_ack || flag_clear.overflow_clear) begin
         ovf_d = 1'b0;
      end
      if (compare_irq_ack || flag_clear.compare_clear) begin
         cmpf_d = 1'b0;
      end
      if (timer_tick) begin
         if (match) begin
            cmpf_d = 1'b1;
         end
         case (mode)
            tmr8_pkg::wave_normal,
            tmr8_pkg::wave_ctc,
            tmr8_pkg::wave_fast:  if (at_max && !cpu_write.count_write)
                                     ovf_d = 1'b1;
            tmr8_pkg::wave_phase: if (down_q && at_bottom && !cpu_write.count_write)
                                     ovf_d = 1'b1;
            default:              ovf_d = ovf_q;
         endcase
         // Waveform actions on a timer tick
         if (com != tmr8_pkg::com_none) begin
            case (mode)
               tmr8_pkg::wave_fast: begin
                  if (match) wave_d = (com == tmr8_pkg::com_set);
                  else if (at_max) wave_d = (com == tmr8_pkg::com_clear);
               end
               tmr8_pkg::wave_phase: begin
                  if (match) wave_d = (com == tmr8_pkg::com_set) ? !down_q : down_q;
               end
               default: begin
                  if (match) begin
                     case (com)
                        tmr8_pkg::com_toggle: wave_d = !wave_q;
                        tmr8_pkg::com_clear:  wave_d = 1'b0;
                        tmr8_pkg::com_set:    wave_d = 1'b1;
                        default:              wave_d = wave_q;
                     endcase
                  end
               end
            endcase
         end
      end
      if (cpu_write.force_compare_strobe && !pwm_mode) begin
         case (com)
            tmr8_pkg::com_toggle: wave_d = !wave_q;
            tmr8_pkg::com_clear:  wave_d = 1'b0;
            tmr8_pkg::com_set:    wave_d = 1'b1;
            default:              wave_d = wave_q;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ovf_q   <= 1'b0;
         cmpf_q  <= 1'b0;
         wave_q  <= 1'b0;
      end else begin
         ovf_q   <= ovf_d;
         cmpf_q  <= cmpf_d;
         wave_q  <= wave_d;
      end
   end

   // *********************************************************************
   // Outputs
   // *********************************************************************
   assign count_value                  = count_q;
   assign compare_value                = pwm_mode ? buffer_q : active_q;
   assign timer_flag_reg.overflow_flag = ovf_q;
   assign timer_flag_reg.compare_flag  = cmpf_q;
   assign overflow_irq = ovf_q && overflow_irq_enable && global_irq_enable;
   assign compare_irq  = cmpf_q && compare_irq_enable && global_irq_enable;
   assign wave_output  = wave_q;

   // *********************************************************************
   // Assertions
   // *********************************************************************
   sequence s_count_write;
      cpu_write.count_write;
   endsequence

   a_cpu_write_wins: assert property (@(posedge clock) disable iff (!rst_n)
      s_count_write |=> count_q == $past(cpu_write.count_wdata))
      else $error("count write not stored");

   a_stopped_holds: assert property (@(posedge clock) disable iff (!rst_n)
      (timer_control_reg.clock_select_field == tmr8_pkg::clk_stopped
       && !cpu_write.count_write) |=> $stable(count_q))
      else $error("stopped counter moved");

   a_normal_up: assert property (@(posedge clock) disable iff (!rst_n)
      (timer_tick && mode == tmr8_pkg::wave_normal && !cpu_write.count_write)
      |=> count_q == 8'($past(count_q) + 8'h01))
      else $error("normal mode not incrementing");

   a_ctc_clear: assert property (@(posedge clock) disable iff (!rst_n)
      (timer_tick && mode == tmr8_pkg::wave_ctc && match_raw && !cpu_write.count_write)
      |=> count_q == tmr8_pkg::count_bottom)
      else $error("ctc did not clear");

   a_compare_irq: assert property (@(posedge clock) disable iff (!rst_n)
      compare_irq == (cmpf_q && compare_irq_enable && global_irq_enable))
      else $error("compare irq mismatch");

   a_flag_clear: assert property (@(posedge clock) disable iff (!rst_n)
      (flag_clear.compare_clear && !(timer_tick && match)) |=> !cmpf_q)
      else $error("compare flag not cleared");

   a_flag_next_tick: assert property (@(posedge clock) disable iff (!rst_n)
      (timer_tick && match) |=> cmpf_q)
      else $error("compare flag not set");

   a_block_match: assert property (@(posedge clock) disable iff (!rst_n)
      s_count_write ##1 (timer_tick && !cpu_write.count_write && !cmpf_q) |=> !cmpf_q)
      else $error("match not blocked after write");

   a_overflow_wrap: assert property (@(posedge clock) disable iff (!rst_n)
      (timer_tick && mode == tmr8_pkg::wave_normal && count_q == tmr8_pkg::count_max
       && !cpu_write.count_write) |=> timer_flag_reg.overflow_flag)
      else $error("overflow not set at wrap");

   a_force_no_flag: assert property (@(posedge clock) disable iff (!rst_n)
      (cpu_write.force_compare_strobe && !timer_tick && !cmpf_q) |=> !cmpf_q)
      else $error("force set compare flag");

   a_buffer_hold: assert property (@(posedge clock) disable iff (!rst_n)
      (pwm_mode && !(timer_tick && at_max) && !cpu_write.compare_write
       && $stable(mode)) |=> $stable(active_q))
      else $error("active compare changed off top");

endmodule : tmr8_timer

// ### tb/tb.sv
/*
 * Self-checking bench for the 8-bit single-compare timer.
 * Assumes tmr8_pkg and tmr8_timer are compiled first; one 50 MHz clock.
 */
`timescale 1ns/10ps
module tb;
   logic                        clock;
   logic                        rst_n;
   tmr8_pkg::timer_control_type ctrl;
   tmr8_pkg::cpu_write_type     cpu;
   tmr8_pkg::flag_clear_type    fclr;
   logic                        ov_ack;
   logic                        cmp_ack;
   logic                        ov_en;
   logic                        cmp_en;
   logic                        gie;
   logic                        pin;
   logic [7:0]                  count_value;
   logic [7:0]                  compare_value;
   tmr8_pkg::timer_flag_type    flags;
   logic                        overflow_irq;
   logic                        compare_irq;
   logic                        wave_output;
   int                          n_errors = 0;
   int                          comparisons = 0;
   int                          cycles = 0;

   tmr8_timer u_tmr8_timer (
      .clock              (clock),
      .rst_n              (rst_n),
      .timer_control_reg  (ctrl),
      .cpu_write          (cpu),
      .flag_clear         (fclr),
      .overflow_irq_ack   (ov_ack),
      .compare_irq_ack    (cmp_ack),
      .overflow_irq_enable(ov_en),
      .compare_irq_enable (cmp_en),
      .global_irq_enable  (gie),
      .external_count_pin (pin),
      .count_value        (count_value),
      .compare_value      (compare_value),
      .timer_flag_reg     (flags),
      .overflow_irq       (overflow_irq),
      .compare_irq        (compare_irq),
      .wave_output        (wave_output)
   );

   // *********************************************************************
   // Clock, timeout and shared tasks
   // *********************************************************************
   initial clock = 1'b0;
   always #10 clock = ~clock;

   // Whole run is a few hundred cycles; generous ceiling
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (n_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask : check

   // Inputs always change 1 ns after the rising edge
   task automatic step(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step

   task automatic set_mode(tmr8_pkg::clock_select_type cs, tmr8_pkg::wave_mode_type wm,
                           logic [1:0] com);
      ctrl.clock_select_field        = cs;
      ctrl.wave_mode_field           = wm;
      ctrl.compare_output_mode_field = com;
   endtask : set_mode

   task automatic wr_count(logic [7:0] v);
      cpu.count_write = 1'b1;
      cpu.count_wdata = v;
      step(1);
      cpu.count_write = 1'b0;
   endtask : wr_count

   task automatic wr_cmp(logic [7:0] v);
      cpu.compare_write = 1'b1;
      cpu.compare_wdata = v;
      step(1);
      cpu.compare_write = 1'b0;
   endtask : wr_cmp

   task automatic clear_flags();
      fclr = '{1'b1, 1'b1};
      step(1);
      fclr = '{1'b0, 1'b0};
   endtask : clear_flags

   task automatic wait_count(logic [7:0] v);
      int i;
      for (i = 0; i < 600 && count_value !== v; i++) step(1);
      check("count reached", v, count_value);
   endtask : wait_count

   // *********************************************************************
   // Scenarios
   // *********************************************************************
   task automatic t_reset();
      check("count", 8'h00, count_value);
      check("compare", 8'h00, compare_value);
      check("flags", 8'h00, {6'h00, flags});
      check("wave", 8'h00, {7'h00, wave_output});
      check("irqs", 8'h00, {6'h00, overflow_irq, compare_irq});
   endtask : t_reset

   task automatic t_stop_write();
      set_mode(tmr8_pkg::clk_stopped, tmr8_pkg::wave_normal, tmr8_pkg::com_none);
      wr_count(8'h5a);
      check("count written", 8'h5a, count_value);
      step(5);
      check("count stopped", 8'h5a, count_value);
   endtask : t_stop_write

   task automatic t_overflow();
      ov_en = 1'b1;
      gie   = 1'b1;
      // Write lands on the same edge as the first tick
      set_mode(tmr8_pkg::clk_div1, tmr8_pkg::wave_normal, tmr8_pkg::com_none);
      wr_count(8'hfd);
      check("count write wins", 8'hfd, count_value);
      step(1);
      check("count up", 8'hfe, count_value);
      step(1);
      check("count max", 8'hff, count_value);
      step(1);
      check("count wrap", 8'h00, count_value);
      check("overflow flag", 8'h01, {7'h00, flags.overflow_flag});
      check("overflow irq", 8'h01, {7'h00, overflow_irq});
      fclr.overflow_clear = 1'b1;
      step(1);
      fclr.overflow_clear = 1'b0;
      check("overflow cleared", 8'h00, {7'h00, flags.overflow_flag});
   endtask : t_overflow

   task automatic t_compare();
      set_mode(tmr8_pkg::clk_stopped, tmr8_pkg::wave_normal, tmr8_pkg::com_none);
      wr_cmp(8'h10);
      check("compare direct", 8'h10, compare_value);
      clear_flags();
      ctrl.clock_select_field = tmr8_pkg::clk_div1;
      wr_count(8'h0e);
      step(2);
      check("flag not yet", 8'h00, {7'h00, flags.compare_flag});
      step(1);
      check("flag set late", 8'h01, {7'h00, flags.compare_flag});
      cmp_en = 1'b1;
      step(1);
      check("irq on", 8'h01, {7'h00, compare_irq});
      gie = 1'b0;
      step(1);
      check("irq global off", 8'h00, {7'h00, compare_irq});
      gie    = 1'b1;
      cmp_en = 1'b0;
      step(1);
      check("irq enable off", 8'h00, {7'h00, compare_irq});
      cmp_en  = 1'b1;
      cmp_ack = 1'b1;
      step(1);
      cmp_ack = 1'b0;
      check("flag acked", 8'h00, {7'h00, flags.compare_flag});
   endtask : t_compare

   task automatic t_block();
      set_mode(tmr8_pkg::clk_stopped, tmr8_pkg::wave_normal, tmr8_pkg::com_none);
      wr_cmp(8'h20);
      clear_flags();
      wr_count(8'h20);
      ctrl.clock_select_field = tmr8_pkg::clk_div1;
      step(4);
      check("match blocked", 8'h00, {7'h00, flags.compare_flag});
   endtask : t_block

   task automatic t_ctc();
      logic [7:0] pc;
      logic       pw;
      set_mode(tmr8_pkg::clk_stopped, tmr8_pkg::wave_normal, tmr8_pkg::com_none);
      wr_cmp(8'h03);
      set_mode(tmr8_pkg::clk_div1, tmr8_pkg::wave_ctc, tmr8_pkg::com_toggle);
      wr_count(8'h00);
      for (int i = 0; i < 12; i++) begin
         pc = count_value;
         pw = wave_output;
         step(1);
         if (pc == 8'h03) begin
            check("ctc clear", 8'h00, count_value);
            check("ctc toggle", {7'h00, ~pw}, {7'h00, wave_output});
         end else begin
            check("ctc count", pc + 8'h01, count_value);
            check("ctc hold", {7'h00, pw}, {7'h00, wave_output});
         end
      end
   endtask : t_ctc

   task automatic t_force();
      logic [1:0] com[6] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h3};
      logic       exp[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
      set_mode(tmr8_pkg::clk_stopped, tmr8_pkg::wave_normal, tmr8_pkg::com_none);
      wr_count(8'h77);
      clear_flags();
      // Strobe held high, so every non-PWM edge forces once
      cpu.force_compare_strobe = 1'b1;
      for (int i = 0; i < 6; i++) begin
         // Mode bits changed right before the strobe act at once
         ctrl.compare_output_mode_field = com[i];
         step(1);
         check("forced wave", {7'h00, exp[i]}, {7'h00, wave_output});
      end
      check("force no flag", 8'h00, {7'h00, flags.compare_flag});
      check("force no count", 8'h77, count_value);
      set_mode(tmr8_pkg::clk_stopped, tmr8_pkg::wave_fast, tmr8_pkg::com_clear);
      step(1);
      cpu.force_compare_strobe = 1'b0;
      check("force ignored pwm", 8'h01, {7'h00, wave_output});
   endtask : t_force

   task automatic t_fast_pwm();
      set_mode(tmr8_pkg::clk_stopped, tmr8_pkg::wave_normal, tmr8_pkg::com_none);
      wr_cmp(8'h90);
      step(1);
      set_mode(tmr8_pkg::clk_stopped, tmr8_pkg::wave_fast, tmr8_pkg::com_clear);
      wr_cmp(8'h40);
      check("compare buffer", 8'h40, compare_value);
      wr_count(8'h80);
      clear_flags();
      ctrl.clock_select_field = tmr8_pkg::clk_div1;
      wait_count(8'h85);
      check("pwm high", 8'h01, {7'h00, wave_output});
      wait_count(8'ha0);
      check("old compare used", 8'h00, {7'h00, wave_output});
      wait_count(8'h10);
      check("set after max", 8'h01, {7'h00, wave_output});
      check("pwm overflow", 8'h01, {7'h00, flags.overflow_flag});
      wait_count(8'h45);
      check("new compare used", 8'h00, {7'h00, wave_output});
   endtask : t_fast_pwm

   task automatic t_phase();
      logic [7:0] seq[7] = '{8'hfe, 8'hff, 8'hfe, 8'hfd, 8'h01, 8'h00, 8'h01};
      rst_n = 1'b0;
      step(2);
      rst_n = 1'b1;
      step(1);
      set_mode(tmr8_pkg::clk_div1, tmr8_pkg::wave_phase, tmr8_pkg::com_none);
      wr_count(8'hfd);
      for (int i = 0; i < 7; i++) begin
         // Write 02 on the falling slope to reach bottom quickly
         if (i == 4) wr_count(8'h02);
         step(1);
         check("phase count", seq[i], count_value);
      end
      check("bottom overflow", 8'h01, {7'h00, flags.overflow_flag});
      ov_ack = 1'b1;
      step(1);
      ov_ack = 1'b0;
      check("overflow acked", 8'h00, {7'h00, flags.overflow_flag});
   endtask : t_phase

   task automatic t_ext();
      pin = 1'b0;
      set_mode(tmr8_pkg::clk_ext_rise, tmr8_pkg::wave_normal, tmr8_pkg::com_none);
      wr_count(8'h00);
      pin = 1'b1;
      step(3);
      check("rise counted", 8'h01, count_value);
      pin = 1'b0;
      step(3);
      check("fall ignored", 8'h01, count_value);
      ctrl.clock_select_field = tmr8_pkg::clk_ext_fall;
      pin = 1'b1;
      step(3);
      check("rise ignored", 8'h01, count_value);
      pin = 1'b0;
      step(3);
      check("fall counted", 8'h02, count_value);
      ctrl.clock_select_field = tmr8_pkg::clk_div8;
      wr_count(8'h00);
      step(80);
      check("div8 rate", 8'h01, {7'h00, count_value >= 8'h09 && count_value <= 8'h0b});
   endtask : t_ext

   // *********************************************************************
   // Main sequence
   // *********************************************************************
   initial begin
      rst_n   = 1'b0;
      ctrl    = '0;
      cpu     = '0;
      fclr    = '0;
      ov_ack  = 1'b0;
      cmp_ack = 1'b0;
      ov_en   = 1'b1;
      cmp_en  = 1'b1;
      gie     = 1'b1;
      pin     = 1'b0;
      step(2);
      rst_n = 1'b1;
      step(1);
      t_reset();
      t_stop_write();
      t_overflow();
      ov_ack = 1'b1;
      step(1);
      ov_ack = 1'b0;
      t_compare();
      t_block();
      t_ctc();
      t_force();
      t_fast_pwm();
      t_phase();
      t_ext();
      stop_test();
   end
endmodule : tb
